// ---- rtl/rsx_exec.sv ----
// rsx_exec: one execution slice of an 8-bit core, reached over apb
// assumes: single clock pclk, apb master keeps psel/penable protocol
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rsx_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake,
  output logic osc_halt,
  output logic [7:0] accumulator
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rsx_pkg::rsx_mode_t mode;
    logic [7:0] acc;
    logic carry;
    logic nibble_borrow_flag;
    logic zero;
    logic sleep_entry_flag;
    logic expiry_flag;
    logic [7:0] watchdog_count;
    logic [7:0] wdog_prescaler;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic halt;
  } rsx_state_t;

  rsx_state_t st;
  rsx_state_t next_st;

  // register file kept outside the struct: 128 words is too wide to pack
  logic [7:0] file_mem [rsx_pkg::FILE_DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic setup;
  logic access;
  logic commit;
  logic is_cmd;
  logic is_acc;
  logic is_flags;
  logic is_wdog;
  logic is_file;
  logic [6:0] file_idx;
  logic [3:0] op;
  logic dest;
  logic [6:0] faddr;
  logic [7:0] lit;
  logic [7:0] fval;
  logic op_known;
  logic op_literal;
  logic op_file;
  logic refuse;
  logic [7:0] flag_byte;
  logic [15:0] wdog_half;
  logic [31:0] read_word;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] result;
  logic alu_carry;
  logic alu_nibble;
  logic alu_zero;
  logic upd_carry;
  logic upd_nibble;
  logic upd_zero;
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;

  // answer chosen at setup; a write lands only at the access edge
  assign setup = psel && !penable;
  assign access = psel && penable && st.ready;
  assign commit = access && pwrite && !st.err;

  assign is_cmd = paddr == rsx_pkg::ADDR_CMD;
  assign is_acc = paddr == rsx_pkg::ADDR_ACC;
  assign is_flags = paddr == rsx_pkg::ADDR_FLAGS;
  assign is_wdog = paddr == rsx_pkg::ADDR_WDOG;
  assign is_file = paddr >= rsx_pkg::ADDR_FILE_BASE &&
                   paddr <= rsx_pkg::ADDR_FILE_LAST;
  assign file_idx = paddr[8:2];
  assign op = pwdata[rsx_pkg::CMD_OP_LSB +: 4];
  assign dest = pwdata[rsx_pkg::CMD_DEST_BIT];
  assign faddr = pwdata[rsx_pkg::CMD_FADDR_LSB +: 7];
  assign lit = pwdata[rsx_pkg::CMD_LIT_LSB +: 8];
  assign fval = file_mem[faddr];
  assign alu_zero = result == 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // opcode classes

  always_comb begin
    op_known = 1'b1;
    op_literal = 1'b0;
    op_file = 1'b0;
    case (op)
      rsx_pkg::OP_NOP,
      rsx_pkg::OP_SLEEP: begin
        op_known = 1'b1;
      end
      rsx_pkg::OP_LITERAL_MINUS_ACCUMULATOR,
      rsx_pkg::OP_EXCLUSIVE_OR_LITERAL: begin
        op_literal = 1'b1;
      end
      rsx_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG,
      rsx_pkg::OP_REGISTER_MINUS_ACCUMULATOR,
      rsx_pkg::OP_NIBBLE_EXCHANGE,
      rsx_pkg::OP_EXCLUSIVE_OR_REGISTER: begin
        op_file = 1'b1;
      end
      default: begin
        op_known = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // refusal, decided in the setup cycle

  always_comb begin
    refuse = 1'b0;
    if (pwrite) begin
      if (is_cmd) begin
        // core clock is stopped while asleep, so commands bounce
        refuse = (st.mode == rsx_pkg::RSX_SLEEP) || !op_known;
      end else if (!is_acc && !is_file) begin
        // flags and watchdog are read-only, anything else unmapped
        refuse = 1'b1;
      end
    end else begin
      refuse = !(is_cmd || is_acc || is_flags || is_wdog || is_file);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read word, captured at setup so it stands through the access cycle

  always_comb begin
    flag_byte = 8'h00;
    flag_byte[rsx_pkg::FLG_CARRY] = st.carry;
    flag_byte[rsx_pkg::FLG_NIBBLE] = st.nibble_borrow_flag;
    flag_byte[rsx_pkg::FLG_ZERO] = st.zero;
    flag_byte[rsx_pkg::FLG_SLEEP_ENTRY] = st.sleep_entry_flag;
    flag_byte[rsx_pkg::FLG_EXPIRY] = st.expiry_flag;
    flag_byte[rsx_pkg::FLG_ASLEEP] = st.halt;
    wdog_half = 16'h0000;
    wdog_half[rsx_pkg::WD_COUNT_LSB +: 8] = st.watchdog_count;
    wdog_half[rsx_pkg::WD_PRESC_LSB +: 8] = st.wdog_prescaler;
    read_word = 32'h0000_0000;
    if (!pwrite) begin
      if (is_acc) begin
        read_word = {24'h00_0000, st.acc};
      end else if (is_flags) begin
        read_word = {24'h00_0000, flag_byte};
      end else if (is_wdog) begin
        read_word = {16'h0000, wdog_half};
      end else if (is_file) begin
        read_word = {24'h00_0000, file_mem[file_idx]};
      end else begin
        // command register reads as zero, unmapped too
        read_word = 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arithmetic: result and flag candidates for the current command

  always_comb begin
    diff = 9'h000;
    ndiff = 5'h00;
    result = 8'h00;
    alu_carry = st.carry;
    alu_nibble = st.nibble_borrow_flag;
    upd_carry = 1'b0;
    upd_nibble = 1'b0;
    upd_zero = 1'b0;
    case (op)
      rsx_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG: begin
        result = {st.carry, fval[7:1]};
        alu_carry = fval[0];
        upd_carry = 1'b1;
      end
      rsx_pkg::OP_LITERAL_MINUS_ACCUMULATOR: begin
        // nine bits so the top bit is the borrow out
        diff = {1'b0, lit} - {1'b0, st.acc};
        ndiff = {1'b0, lit[3:0]} - {1'b0, st.acc[3:0]};
        result = diff[7:0];
        alu_carry = !diff[8];
        alu_nibble = !ndiff[4];
        upd_carry = 1'b1;
        upd_nibble = 1'b1;
        upd_zero = 1'b1;
      end
      rsx_pkg::OP_REGISTER_MINUS_ACCUMULATOR: begin
        diff = {1'b0, fval} - {1'b0, st.acc};
        ndiff = {1'b0, fval[3:0]} - {1'b0, st.acc[3:0]};
        result = diff[7:0];
        alu_carry = !diff[8];
        alu_nibble = !ndiff[4];
        upd_carry = 1'b1;
        upd_nibble = 1'b1;
        upd_zero = 1'b1;
      end
      rsx_pkg::OP_NIBBLE_EXCHANGE: begin
        // no flag touched at all
        result = {fval[3:0], fval[7:4]};
      end
      rsx_pkg::OP_EXCLUSIVE_OR_LITERAL: begin
        result = st.acc ^ lit;
        upd_zero = 1'b1;
      end
      rsx_pkg::OP_EXCLUSIVE_OR_REGISTER: begin
        result = st.acc ^ fval;
        upd_zero = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.ready = setup;
    next_st.err = setup && refuse;
    file_we = 1'b0;
    file_waddr = faddr;
    file_wdata = result;
    if (setup) begin
      next_st.rdata = read_word;
    end
    case (st.mode)
      rsx_pkg::RSX_RUN: begin
        if (commit && is_cmd && op == rsx_pkg::OP_SLEEP) begin
          next_st.mode = rsx_pkg::RSX_SLEEP;
          next_st.halt = 1'b1;
        end
      end
      rsx_pkg::RSX_SLEEP: begin
        // wake-up sits outside this slice; flags survive it
        if (wake) begin
          next_st.mode = rsx_pkg::RSX_RUN;
          next_st.halt = 1'b0;
        end
      end
      default: begin
        next_st.mode = rsx_pkg::RSX_RUN;
        next_st.halt = 1'b0;
      end
    endcase
    if (commit && is_cmd) begin
      if (upd_carry) begin
        next_st.carry = alu_carry;
      end
      if (upd_nibble) begin
        next_st.nibble_borrow_flag = alu_nibble;
      end
      if (upd_zero) begin
        next_st.zero = alu_zero;
      end
      if (op == rsx_pkg::OP_SLEEP) begin
        next_st.sleep_entry_flag = 1'b0;
        next_st.expiry_flag = 1'b1;
        next_st.watchdog_count = rsx_pkg::WDOG_CLEAR;
        next_st.wdog_prescaler = rsx_pkg::PRESC_CLEAR;
      end
      if (op_literal) begin
        // literal forms always land in the accumulator
        next_st.acc = result;
      end else if (op_file) begin
        if (dest) begin
          file_we = 1'b1;
        end else begin
          next_st.acc = result;
        end
      end
    end else if (commit && is_acc) begin
      if (pstrb[0]) begin
        next_st.acc = pwdata[7:0];
      end
    end else if (commit && is_file) begin
      if (pstrb[0]) begin
        file_we = 1'b1;
        file_waddr = file_idx;
        file_wdata = pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.mode <= rsx_pkg::RSX_RUN;
      st.acc <= rsx_pkg::ACC_RESET;
      st.carry <= 1'b0;
      st.nibble_borrow_flag <= 1'b0;
      st.zero <= 1'b0;
      st.sleep_entry_flag <= 1'b1;
      st.expiry_flag <= 1'b1;
      st.watchdog_count <= rsx_pkg::WDOG_CLEAR;
      st.wdog_prescaler <= rsx_pkg::PRESC_CLEAR;
      st.rdata <= 32'h0000_0000;
      st.ready <= 1'b0;
      st.err <= 1'b0;
      st.halt <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // no reset on the file: contents are undefined after power-up
  always_ff @(posedge pclk) begin
    if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign osc_halt = st.halt;
  assign accumulator = st.acc;

endmodule

`default_nettype wire

// ---- rtl/rsx_pkg.sv ----
// rsx_pkg: opcodes, register map, field positions and reset values
// assumes: used by the execution slice only; its bench and checker use literal values
package rsx_pkg;

  // instruction select codes written into the command register
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ROTATE_RIGHT_THROUGH_FLAG = 4'h1;
  localparam logic [3:0] OP_LITERAL_MINUS_ACCUMULATOR = 4'h2;
  localparam logic [3:0] OP_REGISTER_MINUS_ACCUMULATOR = 4'h3;
  localparam logic [3:0] OP_NIBBLE_EXCHANGE = 4'h4;
  localparam logic [3:0] OP_EXCLUSIVE_OR_LITERAL = 4'h5;
  localparam logic [3:0] OP_EXCLUSIVE_OR_REGISTER = 4'h6;
  localparam logic [3:0] OP_SLEEP = 4'h7;

  // apb byte offsets
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_ACC = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_WDOG = 12'h00C;
  localparam logic [11:0] ADDR_FILE_BASE = 12'h200;
  localparam logic [11:0] ADDR_FILE_LAST = 12'h3FC;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 7;
  localparam int CMD_FADDR_LSB = 8;
  localparam int CMD_LIT_LSB = 16;

  // flags register fields
  localparam int FLG_CARRY = 0;
  localparam int FLG_NIBBLE = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_SLEEP_ENTRY = 3;
  localparam int FLG_EXPIRY = 4;
  localparam int FLG_ASLEEP = 5;

  // watchdog register fields
  localparam int WD_COUNT_LSB = 0;
  localparam int WD_PRESC_LSB = 8;

  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_CLEAR = 8'h00;
  localparam int FILE_DEPTH = 128;

  typedef enum logic [1:0] {
    RSX_RUN = 2'b01,
    RSX_SLEEP = 2'b10
  } rsx_mode_t;

endpackage

// ---- verif/rsx_exec_asserts.sv ----
// rsx_exec_chk: port-level properties of the execution slice
// assumes: bound onto rsx_exec, single clock pclk, async presetn
`timescale 1ns/1ps
`default_nettype none
module rsx_exec_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wake,
  input wire logic osc_halt,
  input wire logic [7:0] accumulator
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic su = psel && !penable;
  wire logic cw = su && pwrite && paddr == 12'h000;
  // commands land at the access edge, never when refused
  wire logic cmd = psel && penable && pready && !pslverr && pwrite &&
    paddr == 12'h000;
  wire logic rdh = su && !pwrite && osc_halt;
  wire logic [3:0] op = pwdata[3:0];
  wire logic [7:0] lit = pwdata[23:16];
  ////////////////////////////////////////////////////////////////////
  a_lit_sub_acc: assert property (
    cmd && op == 4'h2 |=> accumulator == $past(lit) - $past(accumulator))
    else $error("literal subtract result wrong");
  a_xor_lit_acc: assert property (
    cmd && op == 4'h5 |=> accumulator == ($past(lit) ^ $past(accumulator)))
    else $error("literal xor result wrong");
  a_dest_keeps_acc: assert property (
    cmd && pwdata[7] && op inside {4'h1, 4'h3, 4'h4, 4'h6}
    |=> $stable(accumulator)) else $error("dest 1 touched accumulator");
  a_sleep_halts: assert property (
    cmd && op == 4'h7 |=> osc_halt) else $error("sleep did not halt");
  a_halt_holds: assert property (
    osc_halt && !wake |=> osc_halt) else $error("halt dropped alone");
  a_halt_refuses: assert property (
    cw && osc_halt |=> pready && pslverr && $stable(accumulator))
    else $error("command ran while halted");
  a_sleep_flags: assert property (
    rdh && paddr == 12'h008 |=> prdata[5:3] == 3'b110)
    else $error("sleep flags wrong");
  a_sleep_wdog: assert property (
    rdh && paddr == 12'h00C |=> prdata[15:0] == 16'h0000)
    else $error("watchdog not cleared");
  a_ready_pulse: assert property (
    su |=> pready ##1 !pready) else $error("pready not one pulse");
  c_sleep: cover property (cmd && op == 4'h7);
  c_refused: cover property (cw && osc_halt);
  c_zero_sub: cover property (cmd && op == 4'h2 ##1 accumulator == 8'h00);
endmodule
bind rsx_exec rsx_exec_chk i_rsx_exec_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wake(wake), .osc_halt(osc_halt),
  .accumulator(accumulator));
`default_nettype wire

// ---- verif/rsx_exec_bench.sv ----
// rsx_exec_bench: directed apb sequences with expected results
// assumes: rsx_pkg, rsx_exec and its checker compiled first
`timescale 1ns/1ps
`default_nettype none
module rsx_exec_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic wake = 0, pslverr, pready, osc_halt, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0] accumulator;
  int err_count = 0, check_count = 0;
  always #12.5 pclk = ~pclk;
  // byte strobes tied: every write here carries a full word
  rsx_exec i_rsx_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake(wake), .osc_halt(osc_halt), .accumulator(accumulator));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // leading edge keeps a release and the next setup apart
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) err_count++;
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("rdata", e, q);
  endtask
  task automatic ca(input logic [7:0] e);
    // settled value, not the edge that launches it
    @(negedge pclk);
    chk("acc", {24'h0, e}, {24'h0, accumulator});
  endtask
  function automatic logic [31:0] cw(input logic [3:0] op,
      input logic d, input logic [6:0] f, input logic [7:0] k);
    return {8'h00, k, 1'b0, f, d, 3'h0, op};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge pclk);
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    ca(8'h00);
    rd(12'h008, 32'h18);
    rd(12'h00C, 32'h0);
    apb(1'b1, 12'h004, 32'h35);
    apb(1'b1, 12'h000, cw(4'h2, 1'b0, 7'h00, 8'h34));
    ca(8'hFF);
    rd(12'h008, 32'h18);
    apb(1'b1, 12'h3FC, 32'h81);
    apb(1'b1, 12'h000, cw(4'h1, 1'b1, 7'h7F, 8'h00));
    rd(12'h3FC, 32'h40);
    ca(8'hFF);
    rd(12'h008, 32'h19);
    apb(1'b1, 12'h000, cw(4'h1, 1'b0, 7'h7F, 8'h00));
    ca(8'hA0);
    rd(12'h008, 32'h18);
    apb(1'b1, 12'h004, 32'h12);
    apb(1'b1, 12'h000, cw(4'h2, 1'b0, 7'h00, 8'h12));
    ca(8'h00);
    rd(12'h008, 32'h1F);
    apb(1'b1, 12'h214, 32'h20);
    apb(1'b1, 12'h004, 32'h21);
    apb(1'b1, 12'h000, cw(4'h3, 1'b1, 7'h05, 8'h00));
    rd(12'h214, 32'hFF);
    ca(8'h21);
    rd(12'h008, 32'h18);
    apb(1'b1, 12'h000, cw(4'h3, 1'b0, 7'h05, 8'h00));
    ca(8'hDE);
    rd(12'h008, 32'h1B);
    apb(1'b1, 12'h000, cw(4'h4, 1'b0, 7'h7F, 8'h00));
    ca(8'h04);
    rd(12'h008, 32'h1B);
    apb(1'b1, 12'h000, cw(4'h5, 1'b0, 7'h00, 8'h04));
    ca(8'h00);
    rd(12'h008, 32'h1F);
    apb(1'b1, 12'h004, 32'h0F);
    apb(1'b1, 12'h000, cw(4'h6, 1'b1, 7'h7F, 8'h00));
    rd(12'h3FC, 32'h4F);
    rd(12'h008, 32'h1B);
    apb(1'b1, 12'h000, cw(4'h0, 1'b0, 7'h00, 8'h00));
    chk("nop_err", 32'h0, {31'h0, se});
    ca(8'h0F);
    apb(1'b1, 12'h000, cw(4'h8, 1'b0, 7'h00, 8'h00));
    chk("bad_op", 32'h1, {31'h0, se});
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0F);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
    apb(1'b1, 12'h008, 32'h0);
    chk("ro_write", 32'h1, {31'h0, se});
    apb(1'b1, 12'h000, cw(4'h7, 1'b0, 7'h00, 8'h00));
    @(negedge pclk);
    chk("halt", 32'h1, {31'h0, osc_halt});
    rd(12'h008, 32'h33);
    rd(12'h00C, 32'h0);
    apb(1'b1, 12'h000, cw(4'h5, 1'b0, 7'h00, 8'hFF));
    chk("asleep_err", 32'h1, {31'h0, se});
    ca(8'h0F);
    @(posedge pclk);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("halt", 32'h0, {31'h0, osc_halt});
    tally_and_finish;
  end
endmodule
`default_nettype wire
